// [bench/smsc_seq_model.sv]
// Model of the instruction sequencer and board straps
`timescale 1ns/1ps
module smsc_seq_model
   import smsc_pkg::*;
(
   input wire logic sys_clk,
   output smsc_seq_evt_t seq_evt,
   output logic [3:0] straps
);
   initial
   begin
      seq_evt = '0;
      straps = 4'h0;
   end
   // Straps: mode, sel, boot a, boot b; board level, changed off the edge
   task automatic set_straps(input logic [3:0] s);
      @(posedge sys_clk);
      straps <= s;
   endtask : set_straps
   // One event, valid for a single edge
   task automatic send(input smsc_ev_kind_t k, input logic [ADDR_W-1:0] a, input logic [PAGE_W-1:0] p);
      @(posedge sys_clk);
      seq_evt <= '{1'b1, k, a, p};
      @(posedge sys_clk);
      seq_evt <= '0;
   endtask : send
   task automatic ret_open(input logic [ADDR_W-1:0] a, input logic [PAGE_W-1:0] p);
      send(SMSC_EV_RET_INT, a, p);
   endtask : ret_open
   task automatic ret_prot();
      send(SMSC_EV_RET_PROT, 14'h0, 16'h0);
   endtask : ret_prot
endmodule : smsc_seq_model

// [bench/test_smsc_top.sv]
// Self-checking bench for the security mode and strap control block
`timescale 1ns/1ps
module test_smsc_top
   import smsc_pkg::*;
   ;
   logic sys_clk, rst_n, avs_read, avs_write, avs_waitrequest, kernel_mode, nested_kernel;
   logic core_reset, host_boot_pci, strap_undefined, irq;
   logic [AW-1:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [1:0] host_personality, boot_source;
   logic [3:0] straps;
   smsc_seq_evt_t seq_evt;
   int n_errors, n_tests, cyc, cnt;
   logic [13:0] ia = 14'h0123;
   logic [15:0] ip = 16'h0001;

   smsc_seq_model u_smsc_seq_model (.sys_clk(sys_clk), .seq_evt(seq_evt), .straps(straps));
   smsc_top u_smsc_top (.sys_clk(sys_clk), .rst_n(rst_n), .seq_evt(seq_evt), .bus_mode_strap(straps[3]),
      .bus_sel_strap(straps[2]), .boot_source_strap_a(straps[1]), .boot_source_strap_b(straps[0]),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .kernel_mode(kernel_mode),
      .nested_kernel(nested_kernel), .core_reset(core_reset), .host_personality(host_personality),
      .boot_source(boot_source), .host_boot_pci(host_boot_pci), .strap_undefined(strap_undefined), .irq(irq));

   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   task automatic stop_test();
      $display("errors %0d comparisons %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test

   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_errors++;
         stop_test();
      end
   end

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // Holds the request until waitrequest is sampled low at a rising edge; the timeout ends a hang
   task automatic bus(input logic wr, input logic [AW-1:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= ~wr;
      avs_write <= wr;
      @(posedge sys_clk);
      while (avs_waitrequest !== 1'b0)
         @(posedge sys_clk);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   task automatic rd(input logic [AW-1:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk("readdata", q, exp);
   endtask : rd

   task automatic ev(input smsc_ev_kind_t k, input logic [ADDR_W-1:0] a, input logic [PAGE_W-1:0] p);
      u_smsc_seq_model.send(k, a, p);
      @(negedge sys_clk);
   endtask : ev

   task automatic enter_open();
      ev(SMSC_EV_JUMP, KERNEL_ENTRY_ADDR, KERNEL_ENTRY_PAGE);
      ev(SMSC_EV_INT_OPEN, ia, ip);
   endtask : enter_open

   // Violation pulse length and cleared mode state
   task automatic viol();
      cnt = 0;
      repeat (7)
      begin
         if (core_reset === 1'b1)
            cnt++;
         @(negedge sys_clk);
      end
      chk("core_reset cycles", cnt, 32'(VIOL_PULSE_CYC));
      chk("kernel after violation", kernel_mode, 1'b0);
      chk("nested after violation", nested_kernel, 1'b0);
   endtask : viol

   task automatic do_reset(input logic [3:0] s);
      u_smsc_seq_model.set_straps(s);
      rst_n <= 1'b0;
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(negedge sys_clk);
   endtask : do_reset

   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   logic [3:0] st [4] = '{4'b1010, 4'b0101, 4'b1100, 4'b0110};
   logic [1:0] ep [4] = '{PERS_PCI, PERS_INTERNAL_MEM, PERS_NONE, PERS_INTERNAL_MEM};
   logic [1:0] eb [4] = '{BOOT_HOST_BUS, BOOT_EXT_PROG, BOOT_BYTE_MEM, BOOT_HOST_BUS};
   initial
   begin
      rst_n = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      for (int i = 3; i >= 0; i--)
      begin
         do_reset(st[i]);
         chk("personality", host_personality, ep[i]);
         chk("boot source", boot_source, eb[i]);
         chk("host boot pci", host_boot_pci, i == 0);
         chk("strap undefined", strap_undefined, i == 2);
         rd(REG_STATUS, (i == 2) ? 32'h8 : 32'h0);
         u_smsc_seq_model.set_straps(~st[i]);
         repeat (4) @(negedge sys_clk);
         chk("personality held", host_personality, ep[i]);
         chk("boot held", boot_source, eb[i]);
      end
      rd(REG_STRAP, 32'h26);
      ev(SMSC_EV_CALL, KERNEL_ENTRY_ADDR, 16'h000e);
      chk("kernel wrong page", kernel_mode, 1'b0);
      ev(SMSC_EV_JUMP, 14'h2001, KERNEL_ENTRY_PAGE);
      chk("kernel wrong addr", kernel_mode, 1'b0);
      ev(SMSC_EV_CALL, KERNEL_ENTRY_ADDR, KERNEL_ENTRY_PAGE);
      chk("kernel entry", kernel_mode, 1'b1);
      ev(SMSC_EV_KDONE, 14'h0, 16'h0);
      chk("kernel done", kernel_mode, 1'b0);
      enter_open();
      chk("open handler", kernel_mode, 1'b0);
      ev(SMSC_EV_CALL, KERNEL_ENTRY_ADDR, KERNEL_ENTRY_PAGE);
      chk("nested", nested_kernel, 1'b1);
      rd(REG_MODE, 32'h3);
      ev(SMSC_EV_CALL, KERNEL_ENTRY_ADDR, KERNEL_ENTRY_PAGE);
      rd(REG_MODE, 32'h3);
      ev(SMSC_EV_KDONE, 14'h0, 16'h0);
      rd(REG_MODE, 32'h2);
      u_smsc_seq_model.ret_open(ia, ip);
      @(negedge sys_clk);
      chk("return match", kernel_mode, 1'b1);
      ev(SMSC_EV_KERR, 14'h0, 16'h0);
      chk("kernel error exit", kernel_mode, 1'b0);
      enter_open();
      ev(SMSC_EV_CALL, KERNEL_ENTRY_ADDR, KERNEL_ENTRY_PAGE);
      ev(SMSC_EV_INT_OPEN, ia, ip);
      viol();
      enter_open();
      u_smsc_seq_model.ret_open(ia + 14'h1, ip);
      @(negedge sys_clk);
      viol();
      ev(SMSC_EV_CALL, KERNEL_ENTRY_ADDR, KERNEL_ENTRY_PAGE);
      repeat (3) ev(SMSC_EV_INT_PROT, ia, ip);
      chk("kernel in protected", kernel_mode, 1'b1);
      rd(REG_MODE, 32'hd);
      repeat (3) u_smsc_seq_model.ret_prot();
      rd(REG_MODE, 32'h1);
      rd(REG_MASK, 32'h0);
      chk("irq masked", irq, 1'b0);
      rd(REG_STATUS, 32'h7);
      bus(1'b1, REG_MASK, 32'hffffffff);
      repeat (2) @(negedge sys_clk);
      chk("irq", irq, 1'b1);
      rd(REG_MASK, 32'hf);
      bus(1'b1, REG_STATUS, 32'h7);
      rd(REG_STATUS, 32'h0);
      chk("irq cleared", irq, 1'b0);
      bus(1'b1, 4'h2, 32'h5);
      rd(4'h2, 32'h0);
      bus(1'b1, REG_MODE, 32'h3);
      rd(REG_MODE, 32'h1);
      stop_test();
   end
endmodule : test_smsc_top

// [hw/smsc_pkg.sv]
// Shared types and constants for the security mode and strap control block
package smsc_pkg;

   // ----------------------------------------------------------------
   // Program flow
   // ----------------------------------------------------------------
   localparam int ADDR_W = 14;
   localparam int PAGE_W = 16;
   localparam logic [ADDR_W-1:0] KERNEL_ENTRY_ADDR = 14'h2000;
   localparam logic [PAGE_W-1:0] KERNEL_ENTRY_PAGE = 16'h000f;

   typedef enum logic [2:0] {
      SMSC_EV_JUMP = 3'b000,
      SMSC_EV_CALL = 3'b001,
      SMSC_EV_INT_OPEN = 3'b010,
      SMSC_EV_INT_PROT = 3'b011,
      SMSC_EV_RET_INT = 3'b100,
      SMSC_EV_RET_PROT = 3'b101,
      SMSC_EV_KDONE = 3'b110,
      SMSC_EV_KERR = 3'b111
   } smsc_ev_kind_t;

   // For interrupts addr/page are the interrupted location, otherwise the target
   typedef struct packed {
      logic valid;
      smsc_ev_kind_t kind;
      logic [ADDR_W-1:0] addr;
      logic [PAGE_W-1:0] page;
   } smsc_seq_evt_t;

   typedef enum logic [1:0] {
      SMSC_USER = 2'b00,
      SMSC_KERNEL = 2'b01,
      SMSC_HANDLER = 2'b10,
      SMSC_NESTED = 2'b11
   } smsc_mode_t;

   // ----------------------------------------------------------------
   // Strap decodes
   // ----------------------------------------------------------------
   localparam logic [1:0] PERS_NONE = 2'h0;
   localparam logic [1:0] PERS_INTERNAL_MEM = 2'h1;
   localparam logic [1:0] PERS_PCI = 2'h2;
   localparam logic [1:0] BOOT_BYTE_MEM = 2'h0;
   localparam logic [1:0] BOOT_HOST_BUS = 2'h1;
   localparam logic [1:0] BOOT_EXT_PROG = 2'h2;
   localparam logic [1:0] BOOT_UNDEF = 2'h3;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam int AW = 4;
   localparam logic [AW-1:0] REG_STATUS = 4'h0;
   localparam logic [AW-1:0] REG_MASK = 4'h4;
   localparam logic [AW-1:0] REG_MODE = 4'h8;
   localparam logic [AW-1:0] REG_STRAP = 4'hc;
   localparam int EVT_W = 4;
   localparam int ST_VIOL = 0;
   localparam int ST_ENTER = 1;
   localparam int ST_EXIT = 2;
   localparam int ST_STRAP_BAD = 3;
   localparam logic [EVT_W-1:0] MASK_RST = 4'h0;
   localparam int DEPTH_W = 16;
   localparam logic [3:0] VIOL_PULSE_CYC = 4'h4;

endpackage : smsc_pkg

// [hw/smsc_top.sv]
// Security mode tracker, violation reset and strap decoder with Avalon-MM registers
//
// Chosen here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps

// Operation
// - Always exactly one of kernel or user mode, switched on the fly.
// - Kernel entered only by jump or call to 0x2000 with page 0x000F.
// - Kernel mode exits by itself on completion or error.
// - Kernel allows open-vector interrupt; handler may re-enter kernel, nesting.
// - Return address and page must match saved ones, else violation reset.
// - At most one nested kernel level below the original one.
// - Open-vector interrupt in nested kernel triggers violation reset.
// - Protected-vector interrupt in kernel keeps kernel mode throughout handler.
// - Protected-vector interrupt nesting has no depth limit or violation; here the depth count saturates at 65535.
// - Personality straps 0/1 select internal memory port, 1/0 select PCI.
// - Personality sampled only during power-up reset, then held fixed.
// - Boot straps 00 byte memory, 10 host bus, 01 external program.
// - Boot straps ignored after power-up reset ends.
// - Host-bus boot uses whichever personality the straps chose.
module smsc_top
   import smsc_pkg::*;
#(
   parameter int DEPTH_WIDTH = DEPTH_W
)(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire smsc_seq_evt_t seq_evt,
   input wire logic bus_mode_strap,
   input wire logic bus_sel_strap,
   input wire logic boot_source_strap_a,
   input wire logic boot_source_strap_b,
   input wire logic [AW-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic kernel_mode,
   output logic nested_kernel,
   output logic core_reset,
   output logic [1:0] host_personality,
   output logic [1:0] boot_source,
   output logic host_boot_pci,
   output logic strap_undefined,
   output logic irq
);

   // ----------------------------------------------------------------
   // Strap capture
   // ----------------------------------------------------------------
   logic [3:0] strap_s1_r, strap_s2_r;
   logic [1:0] pers_r, pers_nxt, boot_r, boot_nxt;
   logic bad_r, bad_nxt, hpci_r, hpci_nxt;

   // Straps are board pins: plain two-stage synchroniser, no reset needed
   always_ff @(posedge sys_clk)
   begin
      strap_s1_r <= {bus_mode_strap, bus_sel_strap, boot_source_strap_a, boot_source_strap_b};
      strap_s2_r <= strap_s1_r;
   end

   always_comb
   begin
      pers_nxt = pers_r;
      boot_nxt = boot_r;
      bad_nxt = bad_r;
      hpci_nxt = hpci_r;
      // Only reset time loads new values; afterwards the pins are dead
      if (!rst_n)
      begin
         unique case (strap_s2_r[3:2])
            2'b01: pers_nxt = PERS_INTERNAL_MEM;
            2'b10: pers_nxt = PERS_PCI;
            default: pers_nxt = PERS_NONE;
         endcase
         bad_nxt = (strap_s2_r[3] == strap_s2_r[2]);
         unique case (strap_s2_r[1:0])
            2'b00: boot_nxt = BOOT_BYTE_MEM;
            2'b10: boot_nxt = BOOT_HOST_BUS;
            2'b01: boot_nxt = BOOT_EXT_PROG;
            default: boot_nxt = BOOT_UNDEF;
         endcase
         hpci_nxt = (strap_s2_r[1:0] == 2'b10) && (strap_s2_r[3:2] == 2'b10);
      end
   end

   always_ff @(posedge sys_clk)
   begin
      pers_r <= pers_nxt;
      boot_r <= boot_nxt;
      bad_r <= bad_nxt;
      hpci_r <= hpci_nxt;
   end

   // ----------------------------------------------------------------
   // Security mode tracking
   // ----------------------------------------------------------------
   smsc_mode_t mode_r, mode_nxt;
   logic [DEPTH_WIDTH-1:0] depth_r, depth_nxt;
   logic [ADDR_W-1:0] sav_addr_r, sav_addr_nxt;
   logic [PAGE_W-1:0] sav_page_r, sav_page_nxt;
   logic viol_ev, enter_ev, exit_ev, is_entry;
   logic [3:0] vcnt_r, vcnt_nxt;

   assign is_entry = seq_evt.valid && (seq_evt.kind == SMSC_EV_JUMP || seq_evt.kind == SMSC_EV_CALL)
                     && seq_evt.addr == KERNEL_ENTRY_ADDR && seq_evt.page == KERNEL_ENTRY_PAGE;

   always_comb
   begin
      mode_nxt = mode_r;
      depth_nxt = depth_r;
      sav_addr_nxt = sav_addr_r;
      sav_page_nxt = sav_page_r;
      viol_ev = 1'b0;
      enter_ev = 1'b0;
      exit_ev = 1'b0;
      if (is_entry && (mode_r == SMSC_USER || mode_r == SMSC_HANDLER))
      begin
         mode_nxt = (mode_r == SMSC_USER) ? SMSC_KERNEL : SMSC_NESTED;
         depth_nxt = '0;
         enter_ev = 1'b1;
      end
      else if (seq_evt.valid && (mode_r == SMSC_KERNEL || mode_r == SMSC_NESTED))
      begin
         unique case (seq_evt.kind)
            SMSC_EV_INT_OPEN:
               if (mode_r == SMSC_NESTED)
                  viol_ev = 1'b1;
               else if (depth_r == '0)
               begin
                  mode_nxt = SMSC_HANDLER;
                  sav_addr_nxt = seq_evt.addr;
                  sav_page_nxt = seq_evt.page;
               end
            // Open vectors from inside a protected handler are not tracked separately
            SMSC_EV_INT_PROT:
               if (depth_r != '1)
                  depth_nxt = depth_r + 1'b1;
            SMSC_EV_RET_PROT:
               if (depth_r != '0)
                  depth_nxt = depth_r - 1'b1;
            SMSC_EV_KDONE, SMSC_EV_KERR:
            begin
               mode_nxt = (mode_r == SMSC_NESTED) ? SMSC_HANDLER : SMSC_USER;
               depth_nxt = '0;
               exit_ev = 1'b1;
            end
            default:
            begin
            end
         endcase
      end
      else if (seq_evt.valid && mode_r == SMSC_HANDLER && seq_evt.kind == SMSC_EV_RET_INT)
      begin
         if (seq_evt.addr == sav_addr_r && seq_evt.page == sav_page_r)
            mode_nxt = SMSC_KERNEL;
         else
            viol_ev = 1'b1;
      end
      if (viol_ev)
      begin
         mode_nxt = SMSC_USER;
         depth_nxt = '0;
      end
      vcnt_nxt = viol_ev ? VIOL_PULSE_CYC : (vcnt_r != 4'h0 ? vcnt_r - 4'h1 : 4'h0);
      if (!rst_n)
      begin
         mode_nxt = SMSC_USER;
         depth_nxt = '0;
         sav_addr_nxt = '0;
         sav_page_nxt = '0;
         vcnt_nxt = 4'h0;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      mode_r <= mode_nxt;
      depth_r <= depth_nxt;
      sav_addr_r <= sav_addr_nxt;
      sav_page_r <= sav_page_nxt;
      vcnt_r <= vcnt_nxt;
   end

   // ----------------------------------------------------------------
   // Registers, interrupt and outputs
   // ----------------------------------------------------------------
   logic [EVT_W-1:0] stat_r, stat_nxt, mask_r, mask_nxt, evt_vec;
   logic [31:0] rdata_r, rdata_nxt;
   logic wait_r, wait_nxt, irq_r, irq_nxt;
   logic kmode_r, kmode_nxt, nest_r, nest_nxt, crst_r, crst_nxt;
   logic wr_take;

   assign wr_take = avs_write && !wait_r;
   assign evt_vec = {bad_r && !rst_n, exit_ev, enter_ev, viol_ev};

   always_comb
   begin
      // One wait cycle, then a single low cycle that ends the transfer
      wait_nxt = !((avs_read || avs_write) && wait_r);
      rdata_nxt = rdata_r;
      if (avs_read && wait_r)
      begin
         unique case (avs_address)
            REG_STATUS: rdata_nxt = {{(32-EVT_W){1'b0}}, stat_r};
            REG_MASK: rdata_nxt = {{(32-EVT_W){1'b0}}, mask_r};
            REG_MODE: rdata_nxt = {{(30-DEPTH_WIDTH){1'b0}}, depth_r, mode_r};
            REG_STRAP: rdata_nxt = {26'h0, hpci_r, bad_r, boot_r, pers_r};
            default: rdata_nxt = 32'h0;
         endcase
      end
      mask_nxt = (wr_take && avs_address == REG_MASK) ? avs_writedata[EVT_W-1:0] : mask_r;
      // Write-one-to-clear; a new event in the same cycle wins
      stat_nxt = stat_r;
      if (wr_take && avs_address == REG_STATUS)
         stat_nxt = stat_r & ~avs_writedata[EVT_W-1:0];
      stat_nxt = stat_nxt | evt_vec;
      irq_nxt = |(stat_nxt & mask_nxt);
      kmode_nxt = (mode_nxt == SMSC_KERNEL || mode_nxt == SMSC_NESTED);
      nest_nxt = (mode_nxt == SMSC_NESTED);
      crst_nxt = (vcnt_nxt != 4'h0);
      if (!rst_n)
      begin
         wait_nxt = 1'b1;
         rdata_nxt = 32'h0;
         mask_nxt = MASK_RST;
         stat_nxt = evt_vec;
         irq_nxt = 1'b0;
         kmode_nxt = 1'b0;
         nest_nxt = 1'b0;
         crst_nxt = 1'b0;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
      mask_r <= mask_nxt;
      stat_r <= stat_nxt;
      irq_r <= irq_nxt;
      kmode_r <= kmode_nxt;
      nest_r <= nest_nxt;
      crst_r <= crst_nxt;
   end

   assign avs_readdata = rdata_r;
   assign avs_waitrequest = wait_r;
   assign kernel_mode = kmode_r;
   assign nested_kernel = nest_r;
   assign core_reset = crst_r;
   assign host_personality = pers_r;
   assign boot_source = boot_r;
   assign host_boot_pci = hpci_r;
   assign strap_undefined = bad_r;
   assign irq = irq_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   mode_flag_sync_a: assert property (kernel_mode == (mode_r == SMSC_KERNEL || mode_r == SMSC_NESTED))
      else $error("kernel flag disagrees with mode");
   entry_only_a: assert property (!kernel_mode && !is_entry
      && !(seq_evt.valid && seq_evt.kind == SMSC_EV_RET_INT) |=> !kernel_mode)
      else $error("kernel entered without proper entry");
   done_exit_a: assert property (mode_r == SMSC_KERNEL && seq_evt.valid
      && (seq_evt.kind == SMSC_EV_KDONE || seq_evt.kind == SMSC_EV_KERR)
      |=> mode_r == SMSC_USER && !kernel_mode ##1 (!kernel_mode || $past(is_entry)))
      else $error("kernel did not exit on completion");
   open_handler_a: assert property (mode_r == SMSC_KERNEL && depth_r == '0 && seq_evt.valid
      && seq_evt.kind == SMSC_EV_INT_OPEN |=> mode_r == SMSC_HANDLER && !kernel_mode)
      else $error("open interrupt did not reach the handler");
   ret_match_a: assert property (mode_r == SMSC_HANDLER && seq_evt.valid && seq_evt.kind == SMSC_EV_RET_INT
      && seq_evt.addr == sav_addr_r && seq_evt.page == sav_page_r |=> mode_r == SMSC_KERNEL && kernel_mode)
      else $error("matching return did not resume kernel");
   ret_mismatch_a: assert property (mode_r == SMSC_HANDLER && seq_evt.valid && seq_evt.kind == SMSC_EV_RET_INT
      && (seq_evt.addr != sav_addr_r || seq_evt.page != sav_page_r) |=> core_reset && mode_r == SMSC_USER)
      else $error("mismatched return not punished");
   single_nest_a: assert property (mode_r == SMSC_NESTED && is_entry |=> mode_r == SMSC_NESTED)
      else $error("nesting went deeper than one level");
   nested_open_a: assert property (mode_r == SMSC_NESTED && seq_evt.valid && seq_evt.kind == SMSC_EV_INT_OPEN
      |=> core_reset [*4] ##1 !core_reset)
      else $error("open interrupt in nested kernel not punished");
   prot_stay_a: assert property (mode_r == SMSC_KERNEL && seq_evt.valid && seq_evt.kind == SMSC_EV_INT_PROT
      |=> mode_r == SMSC_KERNEL && depth_r == $past(depth_r) + 1'b1)
      else $error("protected interrupt left kernel mode");
   pers_hold_a: assert property ($stable(host_personality) && $stable(boot_source))
      else $error("strap decode changed after reset");
   pers_decode_a: assert property (host_personality == PERS_NONE |-> strap_undefined)
      else $error("undefined personality not flagged");
   viol_clear_a: assert property (viol_ev |=> !kernel_mode && !nested_kernel && depth_r == '0)
      else $error("violation left kernel state behind");

   nest_cover_c: cover property (mode_r == SMSC_HANDLER ##[1:20] mode_r == SMSC_NESTED);
   good_return_c: cover property (mode_r == SMSC_HANDLER ##1 mode_r == SMSC_KERNEL);
   viol_cover_c: cover property ($rose(core_reset));
   deep_prot_c: cover property (depth_r == 3);
   nested_viol_c: cover property (mode_r == SMSC_NESTED ##1 core_reset);

endmodule : smsc_top
